// ---- src/xchg_pkg.sv ----
package xchg_pkg;
   // ------------------------------------------------------------------
   // Sizes and constants
   // ------------------------------------------------------------------
   localparam int          TAG_W        = 8;
   localparam int          N_XCHG       = 4;
   localparam int          SEQ_W        = 8;
   localparam int          CNT_W        = 16;
   localparam int          CLK_MHZ      = 100;
   localparam int          SEQ_TMO_US   = 100;
   localparam int          SEQ_TMO_CYC  = SEQ_TMO_US * CLK_MHZ;
   localparam logic [7:0]  NO_TAG       = 8'hff;
   localparam logic [7:0]  ORIG_TAG_BASE = 8'h00;

   // Frame kinds carried on the link.
   typedef enum logic [2:0] {
      FK_DATA,
      FK_ACK,
      FK_SEQ_END,
      FK_XCHG_END,
      FK_ACCEPT,
      FK_REJECT
   } frame_kind_t;

   // Transmission code selection.
   typedef enum logic [1:0] {
      CODE_DEFAULT_8B10B,
      CODE_VARIANT_A,
      CODE_VARIANT_B
   } tx_code_t;

   // Exchange purposes; every one but XP_DATA needs an accept reply to succeed.
   typedef enum logic [2:0] {
      XP_DATA,
      XP_FABRIC_LOGIN,
      XP_ADD_ADDRESS,
      XP_NODE_LOGIN,
      XP_NODE_LOGOUT,
      XP_FABRIC_LOGOUT
   } xchg_purpose_t;

   typedef enum logic [1:0] {
      REC_FREE,
      REC_OPEN,
      REC_SEQ_ACTIVE
   } rec_state_t;

   function automatic logic needs_accept(input xchg_purpose_t p);
      return p != XP_DATA;
   endfunction
endpackage

// ---- src/xchg_link_if.sv ----
`timescale 1ns/1ps
interface xchg_link_if;
   import xchg_pkg::*;
   // Device to peer.
   logic              d_valid;
   frame_kind_t       d_kind;
   logic [TAG_W-1:0]  d_orig_tag;
   logic [TAG_W-1:0]  d_resp_tag;
   logic [SEQ_W-1:0]  d_seq_cnt;
   logic [7:0]        d_port_id;
   logic              d_crc_ok;
   // Peer to device.
   logic              p_valid;
   frame_kind_t       p_kind;
   logic [TAG_W-1:0]  p_orig_tag;
   logic [TAG_W-1:0]  p_resp_tag;
   logic [SEQ_W-1:0]  p_seq_cnt;
   logic [7:0]        p_port_id;
   logic              p_crc_ok;
   // Link-level recovery primitives, and the transmission code selection.
   logic              d_prim_seq;
   logic              p_prim_seq;
   tx_code_t          code_sel;

   modport device (output d_valid, d_kind, d_orig_tag, d_resp_tag, d_seq_cnt, d_port_id,
                   d_crc_ok, d_prim_seq, code_sel,
                   input p_valid, p_kind, p_orig_tag, p_resp_tag, p_seq_cnt, p_port_id,
                   p_crc_ok, p_prim_seq);
   modport peer   (input d_valid, d_kind, d_orig_tag, d_resp_tag, d_seq_cnt, d_port_id,
                   d_crc_ok, d_prim_seq, code_sel,
                   output p_valid, p_kind, p_orig_tag, p_resp_tag, p_seq_cnt, p_port_id,
                   p_crc_ok, p_prim_seq);
endinterface

// ---- src/xchg_originator.sv ----
`timescale 1ns/1ps
module xchg_originator
   import xchg_pkg::*;
#(
   parameter int N       = N_XCHG,
   parameter int TMO_CYC = SEQ_TMO_CYC
)(
   input  wire logic              mclk_in,
   input  wire logic              arst_n_in,
   xchg_link_if.device            link,
   input  wire logic              open_req_in,
   input  wire xchg_purpose_t     open_purpose_in,
   input  wire logic [7:0]        open_port_in,
   output logic                   open_ack_out,
   output logic [TAG_W-1:0]       open_tag_out,
   input  wire logic              send_req_in,
   input  wire logic [TAG_W-1:0]  send_tag_in,
   input  wire logic              send_last_in,
   input  wire logic              send_close_in,
   output logic                   send_ack_out,
   input  wire logic              discard_policy_in,
   input  wire logic              variant_code_in,
   input  wire tx_code_t          variant_sel_in,
   input  wire logic              link_fault_in,
   output logic                   done_out,
   output logic [TAG_W-1:0]       done_tag_out,
   output logic                   done_ok_out,
   output logic                   seq_abort_out,
   output logic [TAG_W-1:0]       abort_tag_out,
   output logic                   link_recovering_out
);
   localparam int IW = $clog2(N);

   rec_state_t        st      [N];
   logic [TAG_W-1:0]  rtag    [N];
   logic [7:0]        port    [N];
   xchg_purpose_t     purp    [N];
   logic [SEQ_W-1:0]  seq_cnt [N];
   logic [SEQ_W-1:0]  exp_cnt [N];
   logic [31:0]       tmo     [N];

   // ------------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------------
   function automatic logic [IW-1:0] idx_of(input logic [TAG_W-1:0] t);
      return IW'(t - ORIG_TAG_BASE);
   endfunction

   logic          free_found;
   logic [IW-1:0] free_idx;
   always_comb begin
      free_found = 1'b0;
      free_idx   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (st[i] == REC_FREE) begin
            free_found = 1'b1;
            free_idx   = IW'(i);
         end
      end
   end

   wire logic [IW-1:0] s_idx    = idx_of(send_tag_in);
   wire logic          s_legal  = send_tag_in < TAG_W'(N) && st[s_idx] != REC_FREE;
   // The peer's echo is only heard, never repeated, so recovery cannot latch itself on.
   wire logic          link_busy = link_fault_in || link.p_prim_seq;
   wire logic          do_open  = open_req_in && free_found && !link_busy;
   wire logic          do_send  = send_req_in && s_legal && !link_busy && !do_open;
   wire logic [IW-1:0] r_idx    = idx_of(link.p_orig_tag);
   // A frame with a bad check word is ignored; the gap shows up as a count miss.
   wire logic          rx_good  = link.p_valid && link.p_crc_ok;
   wire logic          rx_mine  = rx_good && link.p_orig_tag < TAG_W'(N)
                                  && st[r_idx] != REC_FREE
                                  && link.p_port_id == port[r_idx];
   wire logic          rx_gap   = rx_mine && link.p_kind == FK_DATA
                                  && link.p_seq_cnt != exp_cnt[r_idx];

   assign open_ack_out        = do_open;
   assign send_ack_out        = do_send;
   assign link_recovering_out = link_fault_in;
   assign link.d_prim_seq     = link_fault_in;
   assign link.code_sel       = variant_code_in ? variant_sel_in
                                                : CODE_DEFAULT_8B10B;

   // ------------------------------------------------------------------
   // Record table
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < N; i++) begin
            st[i]      <= REC_FREE;
            rtag[i]    <= NO_TAG;
            port[i]    <= '0;
            purp[i]    <= XP_DATA;
            seq_cnt[i] <= '0;
            exp_cnt[i] <= '0;
            tmo[i]     <= '0;
         end
         open_tag_out  <= NO_TAG;
         done_out      <= 1'b0;
         done_tag_out  <= NO_TAG;
         done_ok_out   <= 1'b0;
         seq_abort_out <= 1'b0;
         abort_tag_out <= NO_TAG;
      end else begin
         done_out      <= 1'b0;
         seq_abort_out <= 1'b0;
         for (int i = 0; i < N; i++) begin
            // Each record times out alone, so a stall elsewhere costs nothing.
            if (st[i] == REC_SEQ_ACTIVE) begin
               if (tmo[i] >= 32'(TMO_CYC)) begin
                  tmo[i]        <= '0;
                  seq_abort_out <= 1'b1;
                  abort_tag_out <= ORIG_TAG_BASE + TAG_W'(i);
                  if (discard_policy_in) begin
                     st[i]        <= REC_FREE;
                     rtag[i]      <= NO_TAG;
                     done_out     <= 1'b1;
                     done_ok_out  <= 1'b0;
                     done_tag_out <= ORIG_TAG_BASE + TAG_W'(i);
                  end else begin
                     st[i] <= REC_OPEN;
                  end
               end else begin
                  tmo[i] <= tmo[i] + 32'd1;
               end
            end
         end
         if (do_open) begin
            st[free_idx]      <= REC_OPEN;
            purp[free_idx]    <= open_purpose_in;
            port[free_idx]    <= open_port_in;
            rtag[free_idx]    <= NO_TAG;
            seq_cnt[free_idx] <= '0;
            open_tag_out      <= ORIG_TAG_BASE + TAG_W'(free_idx);
         end
         if (do_send) begin
            // Only one sequence at a time per exchange: a send opens it, last ends it.
            st[s_idx]      <= send_last_in ? REC_OPEN : REC_SEQ_ACTIVE;
            seq_cnt[s_idx] <= send_last_in ? '0 : seq_cnt[s_idx] + SEQ_W'(1);
            tmo[s_idx]     <= '0;
            if (send_close_in && !needs_accept(purp[s_idx])) begin
               st[s_idx]    <= REC_FREE;
               done_out     <= 1'b1;
               done_ok_out  <= 1'b1;
               done_tag_out <= send_tag_in;
            end
         end
         if (rx_mine) begin
            if (rtag[r_idx] == NO_TAG && link.p_resp_tag != NO_TAG)
               rtag[r_idx] <= link.p_resp_tag;
            tmo[r_idx]     <= '0;
            exp_cnt[r_idx] <= link.p_seq_cnt + SEQ_W'(1);
            if (rx_gap) begin
               seq_abort_out <= 1'b1;
               abort_tag_out <= link.p_orig_tag;
               if (discard_policy_in) st[r_idx] <= REC_OPEN;
            end
            if (link.p_kind == FK_ACCEPT || link.p_kind == FK_REJECT
                || link.p_kind == FK_XCHG_END) begin
               st[r_idx]    <= REC_FREE;
               done_out     <= 1'b1;
               done_tag_out <= link.p_orig_tag;
               done_ok_out  <= needs_accept(purp[r_idx]) ? link.p_kind == FK_ACCEPT
                                                         : link.p_kind != FK_REJECT;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Transmit side
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         link.d_valid    <= 1'b0;
         link.d_kind     <= FK_DATA;
         link.d_orig_tag <= NO_TAG;
         link.d_resp_tag <= NO_TAG;
         link.d_seq_cnt  <= '0;
         link.d_port_id  <= '0;
         link.d_crc_ok   <= 1'b1;
      end else begin
         link.d_valid <= do_send;
         if (do_send) begin
            link.d_kind     <= send_close_in ? FK_XCHG_END
                               : send_last_in ? FK_SEQ_END : FK_DATA;
            link.d_orig_tag <= send_tag_in;
            link.d_resp_tag <= rtag[s_idx];
            link.d_seq_cnt  <= seq_cnt[s_idx];
            link.d_port_id  <= port[s_idx];
            link.d_crc_ok   <= 1'b1;
         end
      end
   end
endmodule

// ---- src/xchg_responder.sv ----
`timescale 1ns/1ps
module xchg_responder
   import xchg_pkg::*;
#(
   parameter int N = N_XCHG
)(
   input  wire logic              mclk_in,
   input  wire logic              arst_n_in,
   xchg_link_if.peer              link,
   input  wire logic [7:0]        my_port_in,
   input  wire logic              reply_req_in,
   input  wire frame_kind_t       reply_kind_in,
   input  wire logic [TAG_W-1:0]  reply_orig_in,
   output logic                   reply_ack_out,
   output logic                   rx_frame_out,
   output logic [TAG_W-1:0]       rx_orig_out,
   output logic [TAG_W-1:0]       rx_resp_out
);
   localparam int IW = $clog2(N);

   logic              used [N];
   logic [TAG_W-1:0]  otag [N];

   logic          hit, free_found;
   logic [IW-1:0] hit_idx, free_idx, rp_idx;
   logic          rp_hit;
   // Records are found by the originator tag alone; the own index is not compared.
   always_comb begin
      hit = 1'b0; hit_idx = '0; free_found = 1'b0; free_idx = '0;
      rp_hit = 1'b0; rp_idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (used[i] && otag[i] == link.d_orig_tag) begin
            hit = 1'b1; hit_idx = IW'(i);
         end
         if (!used[i]) begin
            free_found = 1'b1; free_idx = IW'(i);
         end
         if (used[i] && otag[i] == reply_orig_in) begin
            rp_hit = 1'b1; rp_idx = IW'(i);
         end
      end
   end

   wire logic rx_ok   = link.d_valid && link.d_crc_ok && !link.d_prim_seq;
   wire logic do_rep  = reply_req_in && rp_hit && !link.d_prim_seq;
   assign reply_ack_out = do_rep;

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < N; i++) begin
            used[i] <= 1'b0;
            otag[i] <= NO_TAG;
         end
         rx_frame_out    <= 1'b0;
         rx_orig_out     <= NO_TAG;
         rx_resp_out     <= NO_TAG;
         link.p_valid    <= 1'b0;
         link.p_kind     <= FK_ACK;
         link.p_orig_tag <= NO_TAG;
         link.p_resp_tag <= NO_TAG;
         link.p_seq_cnt  <= '0;
         link.p_port_id  <= '0;
         link.p_crc_ok   <= 1'b1;
         link.p_prim_seq <= 1'b0;
      end else begin
         link.p_prim_seq <= link.d_prim_seq;
         rx_frame_out    <= 1'b0;
         link.p_valid    <= 1'b0;
         if (rx_ok && (hit || free_found)) begin
            if (!hit) begin
               used[free_idx] <= 1'b1;
               otag[free_idx] <= link.d_orig_tag;
            end
            rx_frame_out <= 1'b1;
            rx_orig_out  <= link.d_orig_tag;
            rx_resp_out  <= TAG_W'(hit ? hit_idx : free_idx);
            // A closing first frame must not leave a record behind.
            if (link.d_kind == FK_XCHG_END) used[hit ? hit_idx : free_idx] <= 1'b0;
            // Every received frame that finds or gets a record is acknowledged, returning the own tag early.
            link.p_valid    <= 1'b1;
            link.p_kind     <= FK_ACK;
            link.p_orig_tag <= link.d_orig_tag;
            link.p_resp_tag <= TAG_W'(hit ? hit_idx : free_idx);
            link.p_seq_cnt  <= link.d_seq_cnt;
            link.p_port_id  <= my_port_in;
         end else if (do_rep) begin
            link.p_valid    <= 1'b1;
            link.p_kind     <= reply_kind_in;
            link.p_orig_tag <= reply_orig_in;
            link.p_resp_tag <= TAG_W'(rp_idx);
            link.p_seq_cnt  <= '0;
            link.p_port_id  <= my_port_in;
            if (reply_kind_in != FK_ACK && reply_kind_in != FK_DATA) used[rp_idx] <= 1'b0;
         end
      end
   end
endmodule

// ---- verification/exchange_id_tracker_monitor.sv ----
`timescale 1ns/1ps
module exchange_id_tracker_monitor
   import xchg_pkg::*;
#(
   parameter int N = N_XCHG
)(
   input  wire logic             mclk_in,
   input  wire logic             arst_n_in,
   input  wire logic             d_valid,
   input  wire frame_kind_t      d_kind,
   input  wire logic [TAG_W-1:0] d_orig_tag,
   input  wire logic [TAG_W-1:0] d_resp_tag,
   input  wire logic [7:0]       d_port_id,
   input  wire logic             d_crc_ok,
   input  wire logic             d_prim_seq,
   input  wire tx_code_t         code_sel,
   input  wire logic             p_valid,
   input  wire frame_kind_t      p_kind,
   input  wire logic [TAG_W-1:0] p_orig_tag,
   input  wire logic [TAG_W-1:0] p_resp_tag,
   input  wire logic             p_crc_ok
);
   // ------------------------------------------------------------------
   // Wire memory of open exchanges
   // ------------------------------------------------------------------
   // Learning is gated by routed so that a late reply to a closing frame
   // cannot mark a tag that is about to be handed out again.
   logic [TAG_W-1:0] resp_of [N];
   logic [7:0]       port_of [N];
   logic [N-1:0]     learned;
   logic [N-1:0]     routed;
   wire              d_end   = d_valid && (d_kind == FK_XCHG_END);
   wire              p_end   = p_valid && (p_kind == FK_ACCEPT || p_kind == FK_REJECT);
   wire              p_learn = p_valid && p_crc_ok && p_resp_tag != NO_TAG
                               && p_orig_tag < N && routed[p_orig_tag];

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         learned <= '0;
         routed  <= '0;
      end else begin
         if (p_learn) begin
            learned[p_orig_tag] <= 1'b1;
            resp_of[p_orig_tag] <= p_resp_tag;
         end
         if (d_valid && d_orig_tag < N) begin
            routed[d_orig_tag]  <= 1'b1;
            port_of[d_orig_tag] <= d_port_id;
         end
         if (d_end) begin
            learned[d_orig_tag] <= 1'b0;
            routed[d_orig_tag]  <= 1'b0;
         end
         if (p_end) begin
            learned[p_orig_tag] <= 1'b0;
            routed[p_orig_tag]  <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);

   sequence s_fault_held;
      d_prim_seq;
   endsequence
   sequence s_learned_frame;
      d_valid && learned[d_orig_tag];
   endsequence

   a_no_seq_overlap : assert property (d_valid && d_kind == FK_DATA |->
      !(p_valid && p_kind == FK_DATA && p_orig_tag == d_orig_tag))
      else $error("both ends sent data in one exchange at once");
   a_tag_in_range : assert property (d_valid |-> d_orig_tag < N)
      else $error("originator tag outside the record range");
   a_first_untagged : assert property (d_valid && !routed[d_orig_tag] |->
      d_resp_tag == NO_TAG)
      else $error("first frame carried a responder tag");
   a_resp_echoed : assert property (s_learned_frame |->
      d_resp_tag == resp_of[d_orig_tag])
      else $error("learned responder tag not carried");
   a_resp_tag_valid : assert property (p_valid |-> p_resp_tag < N)
      else $error("responder frame without its tag");
   a_port_fixed : assert property (d_valid && routed[d_orig_tag] |->
      d_port_id == port_of[d_orig_tag])
      else $error("exchange moved to another port");
   a_quiet_in_fault : assert property (s_fault_held |=> !d_valid)
      else $error("frame sent during link recovery");
   a_crc_sent_good : assert property (d_valid |-> d_crc_ok)
      else $error("device sent a frame marked corrupt");
   a_code_legal : assert property (code_sel inside
      {CODE_DEFAULT_8B10B, CODE_VARIANT_A, CODE_VARIANT_B})
      else $error("illegal transmission code selected");
endmodule

// ---- verification/exchange_id_tracker_tb_top.sv ----
`timescale 1ns/1ps
module exchange_id_tracker_tb_top;
   import xchg_pkg::*;
   localparam int TMO = 20;
   typedef struct packed {logic [TAG_W-1:0] tag; logic ok;} note_t;
   // ------------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------------
   logic             mclk_in = 1'b0, arst_n_in = 1'b0;
   logic             open_req = 1'b0, send_req = 1'b0, send_last = 1'b0, send_close = 1'b0;
   logic             discard = 1'b0, variant = 1'b0, fault = 1'b0, reply_req = 1'b0;
   xchg_purpose_t    purpose = XP_DATA;
   tx_code_t         vsel = CODE_DEFAULT_8B10B;
   frame_kind_t      reply_kind = FK_ACK;
   logic [7:0]       my_port = 8'h00;
   logic [TAG_W-1:0] send_tag = 8'h00, reply_orig = 8'h00, open_tag, done_tag, rx_orig;
   logic [TAG_W-1:0] resp_seen [4];
   logic [1:0]       corrupt = 2'h0;
   logic             open_ack, send_ack, done, done_ok, recovering, done2, done_ok2, abort2;
   logic             reply_ack, abort1, rx_frame;
   logic [TAG_W-1:0] abort_tag2, rx_resp;
   int               err_count = 0, n_compared = 0, cycles = 0, bad2 = 0, seed = 33103;
   int               n_abort = 0;
   note_t            notes [$];
   note_t            n;
   xchg_link_if link ();
   xchg_link_if link2 ();

   // The second link mirrors the responder, spoiled by the corrupt mode.
   assign link2.p_valid    = link.p_valid;
   assign link2.p_kind     = link.p_kind;
   assign link2.p_orig_tag = link.p_orig_tag;
   assign link2.p_resp_tag = link.p_resp_tag;
   assign link2.p_seq_cnt  = link.p_seq_cnt;
   assign link2.p_port_id  = link.p_port_id ^ {7'h00, corrupt == 2'h2};
   assign link2.p_crc_ok   = link.p_crc_ok & (corrupt != 2'h1);
   assign link2.p_prim_seq = link.p_prim_seq;

   xchg_originator #(.N(N_XCHG), .TMO_CYC(TMO)) u_xchg_originator (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .link(link), .open_req_in(open_req),
      .open_purpose_in(purpose), .open_port_in(my_port), .open_ack_out(open_ack),
      .open_tag_out(open_tag), .send_req_in(send_req), .send_tag_in(send_tag),
      .send_last_in(send_last), .send_close_in(send_close), .send_ack_out(send_ack),
      .discard_policy_in(discard), .variant_code_in(variant), .variant_sel_in(vsel),
      .link_fault_in(fault), .done_out(done), .done_tag_out(done_tag), .done_ok_out(done_ok),
      .seq_abort_out(abort1), .abort_tag_out(), .link_recovering_out(recovering));
   xchg_originator #(.N(N_XCHG), .TMO_CYC(TMO)) u_xchg_originator_2 (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .link(link2), .open_req_in(open_req),
      .open_purpose_in(purpose), .open_port_in(my_port), .open_ack_out(), .open_tag_out(),
      .send_req_in(send_req), .send_tag_in(send_tag), .send_last_in(send_last),
      .send_close_in(send_close), .send_ack_out(), .discard_policy_in(discard),
      .variant_code_in(variant), .variant_sel_in(vsel), .link_fault_in(fault),
      .done_out(done2), .done_tag_out(), .done_ok_out(done_ok2), .seq_abort_out(abort2),
      .abort_tag_out(abort_tag2), .link_recovering_out());
   xchg_responder #(.N(N_XCHG)) u_xchg_responder (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .link(link), .my_port_in(my_port),
      .reply_req_in(reply_req), .reply_kind_in(reply_kind), .reply_orig_in(reply_orig),
      .reply_ack_out(reply_ack), .rx_frame_out(rx_frame), .rx_orig_out(rx_orig),
      .rx_resp_out(rx_resp));
   exchange_id_tracker_monitor #(.N(N_XCHG)) u_exchange_id_tracker_monitor (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .d_valid(link.d_valid), .d_kind(link.d_kind),
      .d_orig_tag(link.d_orig_tag), .d_resp_tag(link.d_resp_tag), .d_port_id(link.d_port_id),
      .d_crc_ok(link.d_crc_ok), .d_prim_seq(link.d_prim_seq), .code_sel(link.code_sel),
      .p_valid(link.p_valid), .p_kind(link.p_kind), .p_orig_tag(link.p_orig_tag),
      .p_resp_tag(link.p_resp_tag), .p_crc_ok(link.p_crc_ok));

   // ------------------------------------------------------------------
   // Clock, watchdog, result watchers
   // ------------------------------------------------------------------
   initial forever #5 mclk_in = ~mclk_in;

   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         $display("unexpected hang: run exceeded 5000 cycles");
         end_sim();
      end
   end

   always @(posedge mclk_in) begin
      if (link.p_valid === 1'b1) resp_seen[link.p_orig_tag[1:0]] <= link.p_resp_tag;
      if (done2 === 1'b1 && done_ok2 === 1'b1 && corrupt != 2'h0) bad2++;
      if (abort1 === 1'b1) n_abort++;
      if (done === 1'b1) begin
         n = (notes.size() != 0) ? notes.pop_front() : '{NO_TAG, 1'b0};
         chk("done_tag", n.tag, done_tag);
         chk("done_ok", n.ok, done_ok);
      end
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic open_x(input xchg_purpose_t p, output logic ack, output logic [TAG_W-1:0] t);
      @(negedge mclk_in);
      purpose = p;
      open_req = 1'b1;
      #1 ack = open_ack;
      @(negedge mclk_in);
      open_req = 1'b0;
      t = open_tag;
   endtask

   task automatic send_x(input logic [TAG_W-1:0] t, input logic l, c,
                         output logic [TAG_W-1:0] o, r);
      @(negedge mclk_in);
      send_tag = t;
      send_last = l;
      send_close = c;
      send_req = 1'b1;
      #1 chk("send_ack", 1, send_ack);
      @(negedge mclk_in);
      send_req = 1'b0;
      o = link.d_orig_tag;
      r = link.d_resp_tag;
      chk("d_valid", 1, link.d_valid);
   endtask

   task automatic reply_x(input frame_kind_t k, input logic [TAG_W-1:0] t);
      @(negedge mclk_in);
      chk("rx_orig", t, rx_orig);
      chk("rx_frame", 1, rx_frame);
      chk("rx_resp range", 1, rx_resp < N_XCHG);
      reply_kind = k;
      reply_orig = t;
      reply_req = 1'b1;
      #1 chk("reply_ack", 1, reply_ack);
      @(negedge mclk_in);
      reply_req = 1'b0;
      repeat (3) @(negedge mclk_in);
   endtask

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin : main
      logic             ack, seen;
      logic [TAG_W-1:0] t, o, r;
      logic [TAG_W-1:0] tags [4];
      int               k;
      my_port = 8'($random(seed));
      repeat (10) @(posedge mclk_in);
      @(negedge mclk_in) arst_n_in = 1'b1;
      chk("open_tag reset", NO_TAG, open_tag);
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk_in);
         variant = i[0];
         vsel = tx_code_t'(i / 2);
         #1 chk("code_sel", i[0] ? i / 2 : CODE_DEFAULT_8B10B, link.code_sel);
      end
      variant = 1'b0;
      $display("test code selection done");
      for (int i = 0; i < 4; i++) begin
         open_x(XP_DATA, ack, tags[i]);
         chk("open_ack", 1, ack);
         chk("tag range", 1, tags[i] < N_XCHG);
         for (int j = 0; j < i; j++) chk("tags distinct", 1, tags[j] != tags[i]);
      end
      open_x(XP_DATA, ack, t);
      chk("open when full", 0, ack);
      for (int i = 0; i < 4; i++) begin
         send_x(tags[i], 1'b0, 1'b0, o, r);
         chk("first orig tag", tags[i], o);
         chk("first resp tag", NO_TAG, r);
         reply_x(FK_ACK, tags[i]);
         send_x(tags[i], 1'b1, 1'b0, o, r);
         chk("later resp tag", resp_seen[tags[i][1:0]], r);
         notes.push_back('{tags[i], 1'b1});
         send_x(tags[i], 1'b0, 1'b1, o, r);
      end
      repeat (3) @(negedge mclk_in);
      open_x(XP_DATA, ack, t);
      chk("reopen after close", 1, ack);
      notes.push_back('{t, 1'b1});
      send_x(t, 1'b0, 1'b1, o, r);
      $display("test tags and records done");
      for (int i = 1; i < 6; i++) begin
         open_x(xchg_purpose_t'(i), ack, t);
         send_x(t, 1'b1, 1'b0, o, r);
         notes.push_back('{t, ~i[0]});
         reply_x(i[0] ? FK_REJECT : FK_ACCEPT, t);
      end
      $display("test login outcomes done");
      @(negedge mclk_in) fault = 1'b1;
      open_x(XP_DATA, ack, t);
      chk("open in fault", 0, ack);
      chk("recovering", 1, recovering);
      chk("prim_seq", 1, link.d_prim_seq);
      @(negedge mclk_in) fault = 1'b0;
      $display("test link fault done");
      discard = 1'b1;
      for (int m = 1; m < 3; m++) begin
         corrupt = 2'(m);
         open_x(XP_NODE_LOGIN, ack, t);
         // The sequence stays open, so the spoiled copy can only leave it by timing out.
         send_x(t, 1'b0, 1'b0, o, r);
         notes.push_back('{t, 1'b1});
         reply_x(FK_ACCEPT, t);
         seen = 1'b0;
         for (k = 0; k < TMO + 20 && !seen; k++) @(negedge mclk_in) seen = (abort2 === 1'b1);
         chk("corrupt link abort", 1, seen);
         chk("abort tag", t, abort_tag2);
         repeat (3) @(negedge mclk_in);
      end
      corrupt = 2'h0;
      chk("accept through bad frames", 0, bad2);
      chk("abort on good link", 0, n_abort);
      $display("test corrupted frames done");
      for (k = 0; k < 50 && notes.size() != 0; k++) @(negedge mclk_in);
      chk("notes left", 0, notes.size());
      end_sim();
   end
endmodule
